// ### logic/bsp_pkg.sv
// Constants and types shared by the boot-section self-programming logic.
package bsp_pkg;

  localparam int unsigned PC_W          = 12;
  localparam int unsigned PTR_W         = 16;
  localparam int unsigned PAGE_W        = 7;
  localparam int unsigned WORD_W        = 5;
  localparam int unsigned PAGE_WORDS    = 32;
  localparam int unsigned PC_TOP_BIT    = 11;
  localparam int unsigned PTR_PC_TOP    = 12;
  localparam int unsigned PTR_PAGE_LSB  = 6;
  localparam int unsigned PTR_WORD_TOP  = 5;
  localparam int unsigned PTR_WORD_LSB  = 1;
  localparam int unsigned PTR_BYTE_SEL  = 0;

  // Boot region starts for each boot-size fuse setting, then the read-while-write region bounds.
  localparam logic [11:0] BOOT_START_11 = 12'hF80;
  localparam logic [11:0] BOOT_START_10 = 12'hF00;
  localparam logic [11:0] BOOT_START_01 = 12'hE00;
  localparam logic [11:0] BOOT_START_00 = 12'hC00;
  localparam logic [11:0] NO_READ_WHILE_WRITE_REGION_START    = 12'hC00;
  localparam logic [11:0] RWW_LAST      = 12'hBFF;

  // Command codes written to the control register; bit 7 is never stored, so it is a don't-care for every code.
  localparam logic [7:0] CMD_BUF_LOAD   = 8'h01;
  localparam logic [6:0] CMD_ERASE      = 7'h03;
  localparam logic [6:0] CMD_WRITE      = 7'h05;
  localparam logic [6:0] CMD_LOCK       = 7'h09;
  localparam logic [6:0] CMD_REENABLE   = 7'h11;
  localparam logic [2:0] CMD_WINDOW     = 3'h4;

  // Programming time limits and the oscillator tick rate that times them.
  localparam real         PROG_MIN_MS   = 3.7;
  localparam real         PROG_MAX_MS   = 4.5;
  localparam real         OSC_KHZ       = 128.0;
  localparam int unsigned PROG_TICKS    = int'($ceil(PROG_MIN_MS * OSC_KHZ));
  localparam int unsigned PROG_TICK_MAX = int'($floor(PROG_MAX_MS * OSC_KHZ));
  localparam int unsigned TCNT_W        = 10;

  typedef enum logic [1:0] {
    BSP_IDLE  = 2'b00,
    BSP_ARMED = 2'b01,
    BSP_BUSY  = 2'b11
  } bsp_state_type;

  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_LOCK  = 2'h3
  } bsp_op_type;

endpackage

// ### logic/bsp_region_decode.sv
// Boot-size fuse decode and region classification of one word address.
`timescale 1ns/1ps
module bsp_region_decode (
  // Fuses.
  input  wire logic        boot_size_select_hi,
  input  wire logic        boot_size_select_lo,
  // Address under test.
  input  wire logic [11:0] word_addr,
  // Decode results.
  output logic      [11:0] boot_start,
  output logic      [11:0] app_end,
  output logic             in_boot_region,
  output logic             in_rww_region
);

  always_comb begin
    case ({boot_size_select_hi, boot_size_select_lo})
      2'b11:   boot_start = bsp_pkg::BOOT_START_11; // RULE1
      2'b10:   boot_start = bsp_pkg::BOOT_START_10; // RULE1
      2'b01:   boot_start = bsp_pkg::BOOT_START_01; // RULE2
      default: boot_start = bsp_pkg::BOOT_START_00; // RULE2
    endcase
  end

  assign app_end        = boot_start - 12'h001; // RULE2
  assign in_boot_region = (word_addr >= boot_start);
  assign in_rww_region  = (word_addr <= bsp_pkg::RWW_LAST); // RULE3

endmodule

// ### logic/bsp_self_program.sv
// Self-programming sequencer: command arming, pointer mapping, timing and region blocking.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Fuses 11/10 give boot start F80/F00.
// RULE2: Fuses 01/00 give boot start E00/C00.
// RULE3: Words 000-BFF read-while-write, C00-FFF not.
// RULE4: During erase/write only other region readable.
// RULE5: Program counter is twelve bits wide.
// RULE6: Pointer bits 5..1 select word in page.
// RULE7: Pointer bits 12..6 select the page.
// RULE8: Software zeroes word bits for page write.
// RULE9: Pointer bits 15..13 are always ignored.
// RULE10: Pointer bit 0 selects byte on load.
// RULE11: Each operation lasts 3.7 to 4.5 ms.
// RULE12: Operations timed by the RC oscillator.
// RULE13: Write in progress survives a reset.
// RULE14: Software polls enable bit before commands.
// RULE15: Software masks interrupts, waits EEPROM idle.
// RULE16: Software follows erase, load, write order.
// RULE17: Software locks boot region when unneeded.
// RULE18: Command codes; store within four cycles.
// RULE19: Busy flag set, cleared by reenable/load.
// RULE20: Fetches to busy region are stalled.
// RULE21: CPU halted for no-read-region operations.
module bsp_self_program (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Fuses and oscillator tick.
  input  wire logic        boot_size_select_hi,
  input  wire logic        boot_size_select_lo,
  input  wire logic        osc_tick,
  // Control register write from the core, and the EEPROM write status.
  input  wire logic        ctrl_wr,
  input  wire logic [7:0]  ctrl_wdata,
  input  wire logic        eeprom_write_active,
  // Store instruction.
  input  wire logic        store_req,
  input  wire logic [15:0] pointer,
  input  wire logic [15:0] store_data,
  // Instruction fetch and program-memory load.
  input  wire logic [11:0] fetch_addr,
  input  wire logic        load_req,
  input  wire logic [15:0] load_ptr,
  // Status outputs.
  output logic             self_program_enable,
  output logic             region_busy_flag,
  output logic             cpu_halt,
  output logic             fetch_stall,
  output logic             load_stall,
  output logic             op_done,
  // Flash array strobes, addresses and data, and the boot region decode.
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_lock,
  output logic [6:0]       page_select_field,
  output logic [4:0]       buf_word_addr,
  output logic [15:0]      buf_word_data,
  output logic             buf_load,
  output logic             buf_clear,
  output logic [11:0]      load_word_addr,
  output logic             load_byte_hi,
  output logic [11:0]      boot_start,
  output logic [11:0]      app_end
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    bsp_pkg::bsp_state_type state;
    bsp_pkg::bsp_op_type    op;
    logic [6:0]             cmd;
    logic [2:0]             win;
    logic [9:0]             ticks;
    logic                   busy_rww;
    logic                   halt;
    logic [6:0]             page;
    logic                   erase_p;
    logic                   write_p;
    logic                   lock_p;
    logic                   load_p;
    logic                   clr_p;
    logic                   done_p;
    logic [4:0]             waddr;
    logic [15:0]            wdata;
    logic [9:0]             span;
  } bsp_regs_type;

  bsp_regs_type st_r;
  bsp_regs_type st_nxt;
  logic [6:0]   z_page;
  logic [4:0]   z_word;
  logic [11:0]  z_target;
  logic         tgt_rww;
  logic         fetch_rww;
  logic         load_rww;
  logic         cmd_buf;
  logic         cmd_ers;
  logic         cmd_wrt;
  logic         cmd_lck;
  logic         cmd_ren;
  logic         fire;

  ////////////////////////////////////////////////////////////////////////////////
  assign z_page   = pointer[bsp_pkg::PTR_PC_TOP:bsp_pkg::PTR_PAGE_LSB]; // RULE7 RULE9
  assign z_word   = pointer[bsp_pkg::PTR_WORD_TOP:bsp_pkg::PTR_WORD_LSB]; // RULE6
  assign z_target = {z_page, 5'h00}; // RULE5

  bsp_region_decode u_dec (
    .boot_size_select_hi (boot_size_select_hi),
    .boot_size_select_lo (boot_size_select_lo),
    .word_addr           (z_target),
    .boot_start          (boot_start),
    .app_end             (app_end),
    .in_boot_region      (),
    .in_rww_region       (tgt_rww)
  );

  assign fetch_rww = (fetch_addr <= bsp_pkg::RWW_LAST); // RULE3
  assign load_rww  = (load_ptr[bsp_pkg::PTR_PC_TOP:bsp_pkg::PTR_WORD_LSB] <= bsp_pkg::RWW_LAST);

  assign cmd_buf = ({1'b0, st_r.cmd} == bsp_pkg::CMD_BUF_LOAD); // RULE18
  assign cmd_ers = (st_r.cmd == bsp_pkg::CMD_ERASE);
  assign cmd_wrt = (st_r.cmd == bsp_pkg::CMD_WRITE);
  assign cmd_lck = (st_r.cmd == bsp_pkg::CMD_LOCK);
  assign cmd_ren = (st_r.cmd == bsp_pkg::CMD_REENABLE);
  assign fire    = (st_r.state == bsp_pkg::BSP_ARMED) && store_req; // RULE18

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes fall back to zero every cycle so that each lasts one clock, except buf_clear, which stays high for as long as an idle reset is held.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.erase_p = 1'b0;
    st_nxt.write_p = 1'b0;
    st_nxt.lock_p  = 1'b0;
    st_nxt.load_p  = 1'b0;
    st_nxt.clr_p   = 1'b0;
    st_nxt.done_p  = 1'b0;
    // Oscillator periods since the last operation strobe, counted apart from the timer.
    if (st_r.erase_p || st_r.write_p || st_r.lock_p) begin
      st_nxt.span = osc_tick ? 10'h001 : 10'h000;
    end else if (osc_tick && st_r.span != 10'h3FF) begin
      st_nxt.span = st_r.span + 10'h001;
    end
    case (st_r.state)
      bsp_pkg::BSP_IDLE: begin
        if (ctrl_wr && ctrl_wdata[0] && !eeprom_write_active) begin
          st_nxt.state = bsp_pkg::BSP_ARMED;
          st_nxt.cmd   = ctrl_wdata[6:0];
          st_nxt.win   = '0;
        end
      end
      bsp_pkg::BSP_ARMED: begin
        if (fire) begin
          st_nxt.state = bsp_pkg::BSP_IDLE;
          if (cmd_buf) begin
            st_nxt.load_p   = 1'b1;
            st_nxt.waddr    = z_word; // RULE6
            st_nxt.wdata    = store_data;
            st_nxt.busy_rww = 1'b0; // RULE19
          end else if (cmd_ren) begin
            st_nxt.clr_p    = 1'b1;
            st_nxt.busy_rww = 1'b0; // RULE19
          end else if (cmd_ers || cmd_wrt || cmd_lck) begin
            st_nxt.state    = bsp_pkg::BSP_BUSY;
            st_nxt.ticks    = '0;
            st_nxt.page     = z_page; // RULE7
            st_nxt.erase_p  = cmd_ers;
            st_nxt.write_p  = cmd_wrt;
            st_nxt.lock_p   = cmd_lck;
            st_nxt.op       = cmd_ers ? bsp_pkg::OP_ERASE :
                              cmd_wrt ? bsp_pkg::OP_WRITE : bsp_pkg::OP_LOCK;
            st_nxt.busy_rww = (cmd_ers || cmd_wrt) && tgt_rww; // RULE19 RULE4
            st_nxt.halt     = (cmd_ers || cmd_wrt) && !tgt_rww; // RULE21
          end
        end else if (st_r.win == bsp_pkg::CMD_WINDOW - 3'h1) begin
          st_nxt.state = bsp_pkg::BSP_IDLE; // RULE18
        end else begin
          st_nxt.win = st_r.win + 3'h1;
        end
      end
      bsp_pkg::BSP_BUSY: begin
        if (osc_tick) begin // RULE12
          if (st_r.ticks == 10'(bsp_pkg::PROG_TICKS - 1)) begin // RULE11
            st_nxt.state  = bsp_pkg::BSP_IDLE;
            st_nxt.op     = bsp_pkg::OP_NONE;
            st_nxt.halt   = 1'b0;
            st_nxt.done_p = 1'b1;
            st_nxt.clr_p  = (st_r.op == bsp_pkg::OP_WRITE);
          end else begin
            st_nxt.ticks = st_r.ticks + 10'h001;
          end
        end
      end
      default: st_nxt.state = bsp_pkg::BSP_IDLE;
    endcase
  end

  // A reset during an operation lets it finish; an unknown state is cleared by reset.
  always_ff @(posedge clk) begin
    if (srst && st_r.state == bsp_pkg::BSP_BUSY) begin
      st_r <= st_nxt; // RULE13
    end else if (srst) begin
      st_r       <= '0;
      st_r.clr_p <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign self_program_enable = (st_r.state != bsp_pkg::BSP_IDLE);
  assign region_busy_flag    = st_r.busy_rww;
  assign cpu_halt            = st_r.halt; // RULE21
  assign fetch_stall         = st_r.busy_rww && fetch_rww; // RULE20 RULE4
  assign load_stall          = st_r.busy_rww && load_req && load_rww; // RULE20
  assign op_done             = st_r.done_p;
  assign flash_erase         = st_r.erase_p;
  assign flash_write         = st_r.write_p;
  assign flash_lock          = st_r.lock_p;
  assign page_select_field   = st_r.page;
  assign buf_word_addr       = st_r.waddr;
  assign buf_word_data       = st_r.wdata;
  assign buf_load            = st_r.load_p;
  assign buf_clear           = st_r.clr_p;
  assign load_word_addr      = load_ptr[bsp_pkg::PTR_PC_TOP:bsp_pkg::PTR_WORD_LSB]; // RULE9
  assign load_byte_hi        = load_ptr[bsp_pkg::PTR_BYTE_SEL]; // RULE10

  ////////////////////////////////////////////////////////////////////////////////
  // Steps shared by the checks below.
  sequence seq_armed_wait;
    st_r.state == bsp_pkg::BSP_ARMED && !store_req;
  endsequence
  sequence seq_fire_prog;
    fire && (cmd_ers || cmd_wrt);
  endsequence
  sequence seq_fire_op;
    fire && (cmd_ers || cmd_wrt || cmd_lck);
  endsequence
  sequence seq_busy_reset;
    srst && st_r.state == bsp_pkg::BSP_BUSY;
  endsequence

  chk_window_lapse: assert property (@(posedge clk) disable iff (srst) // RULE18
    seq_armed_wait [*4] |=> !self_program_enable)
    else $error("armed command did not lapse");
  chk_busy_set: assert property (@(posedge clk) disable iff (srst) // RULE19
    seq_fire_prog ##0 tgt_rww |=> region_busy_flag)
    else $error("busy flag not set");
  chk_busy_clr: assert property (@(posedge clk) disable iff (srst) // RULE19
    fire && cmd_buf |=> !region_busy_flag)
    else $error("busy flag not cleared by load");
  chk_fetch_stall: assert property (@(posedge clk) disable iff (srst) // RULE20
    region_busy_flag && fetch_addr <= 12'hBFF |-> fetch_stall)
    else $error("fetch to busy region not stalled");
  chk_no_read_while_write_region_free: assert property (@(posedge clk) disable iff (srst) // RULE4
    fetch_addr >= 12'hC00 |-> !fetch_stall)
    else $error("no-read-while-write fetch stalled");
  chk_halt_no_read_while_write_region: assert property (@(posedge clk) disable iff (srst) // RULE21
    seq_fire_prog ##0 !tgt_rww |=> cpu_halt && self_program_enable)
    else $error("cpu not halted");
  chk_min_time: assert property (@(posedge clk) disable iff (srst) // RULE11
    flash_erase |-> self_program_enable [*8])
    else $error("operation ended too early");
  chk_page_map: assert property (@(posedge clk) disable iff (srst) // RULE7
    fire && cmd_wrt |=> page_select_field == $past(pointer[12:6]))
    else $error("page field wrong");
  chk_boot_start: assert property (@(posedge clk) disable iff (srst) // RULE1
    boot_size_select_hi && boot_size_select_lo |-> boot_start == 12'hF80)
    else $error("boot start wrong");
  chk_op_span: assert property (@(posedge clk) disable iff (srst) // RULE11
    op_done |-> st_r.span >= 10'(bsp_pkg::PROG_TICKS) &&
                st_r.span <= 10'(bsp_pkg::PROG_TICK_MAX))
    else $error("operation length outside limits");
  chk_op_strobe: assert property (@(posedge clk) disable iff (srst) // RULE18
    seq_fire_op |=> self_program_enable && (flash_erase || flash_write || flash_lock))
    else $error("operation strobe missing");
  chk_reset_ride: assert property (@(posedge clk) // RULE13
    seq_busy_reset |=> self_program_enable || op_done)
    else $error("operation cut short by reset");
  chk_reset_clear: assert property (@(posedge clk) // RULE13
    srst && !self_program_enable |=> buf_clear && !region_busy_flag)
    else $error("idle reset did not clear state");
  chk_word_map: assert property (@(posedge clk) disable iff (srst) // RULE6
    fire && cmd_buf |=> buf_load && buf_word_addr == $past(pointer[5:1]))
    else $error("buffer word address wrong");
  chk_reenable: assert property (@(posedge clk) disable iff (srst) // RULE19
    fire && cmd_ren |=> !region_busy_flag && buf_clear)
    else $error("reenable did not clear busy flag");
  chk_eeprom_block: assert property (@(posedge clk) disable iff (srst) // RULE15
    !self_program_enable && eeprom_write_active |=> !self_program_enable)
    else $error("command armed during eeprom write");
  chk_load_stall: assert property (@(posedge clk) disable iff (srst) // RULE20
    region_busy_flag && load_req && load_word_addr <= 12'hBFF |-> load_stall)
    else $error("load from busy region not stalled");
  chk_halt_done: assert property (@(posedge clk) disable iff (srst) // RULE21
    op_done |-> !cpu_halt)
    else $error("cpu still halted after operation");
  chk_lock_free: assert property (@(posedge clk) disable iff (srst) // RULE4
    seq_fire_op ##0 cmd_lck |=> flash_lock && !cpu_halt)
    else $error("lock write halted the cpu");

endmodule

// ### verif/bsp_core_model.sv
// Core model that issues control writes and store instructions like boot loader code.
`timescale 1ns/1ps
module bsp_core_model (
  // Clock and status.
  input  wire logic        clk,
  input  wire logic        self_program_enable,
  input  wire logic        eeprom_write_active,
  // Command side.
  output logic             ctrl_wr,
  output logic [7:0]       ctrl_wdata,
  output logic             store_req,
  output logic [15:0]      pointer,
  output logic [15:0]      store_data
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    store_req = 1'b0;
    pointer = 16'h0000;
    store_data = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Waits for an idle engine, writes the code, then stores after gap idle cycles.
  task automatic issue(input logic [7:0] code, input logic [15:0] ptr,
                       input logic [15:0] dat, input int gap);
    while (self_program_enable !== 1'b0 || eeprom_write_active !== 1'b0) begin
      @(negedge clk);
    end
    ctrl_wr <= 1'b1;
    ctrl_wdata <= code;
    @(negedge clk);
    ctrl_wr <= 1'b0;
    ctrl_wdata <= ~code;
    repeat (gap) @(negedge clk);
    store_req <= 1'b1;
    pointer <= ptr;
    store_data <= dat;
    @(negedge clk);
    // Operands are not held once the store has been taken.
    store_req <= 1'b0;
    pointer <= ~ptr;
    store_data <= ~dat;
  endtask
endmodule

// ### verif/tb_bsp_self_program.sv
// Self-checking bench for the self-programming sequencer.
`timescale 1ns/1ps
module tb_bsp_self_program;
  logic        clk = 1'b0, srst = 1'b1, osc_tick = 1'b0, load_req = 1'b0;
  logic        boot_size_select_hi = 1'b1, boot_size_select_lo = 1'b1;
  logic        eeprom_write_active = 1'b0;
  logic [11:0] fetch_addr = 12'h000;
  logic [15:0] load_ptr = 16'h0000;
  logic        ctrl_wr, store_req, self_program_enable, region_busy_flag, cpu_halt;
  logic        fetch_stall, load_stall, op_done, flash_erase, flash_write, flash_lock;
  logic        buf_load, buf_clear, load_byte_hi;
  logic [7:0]  ctrl_wdata;
  logic [15:0] pointer, store_data, buf_word_data;
  logic [6:0]  page_select_field;
  logic [4:0]  buf_word_addr;
  logic [11:0] load_word_addr, boot_start, app_end;
  logic [31:0] seed = 32'h00013B43;
  int          n_fail = 0, n_checks = 0, cyc = 0;

  always #4 clk = ~clk;
  // Oscillator ticks come much faster than the real rate to keep the run short.
  always @(negedge clk) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 4) == 0;
  end

  bsp_self_program i_bsp_self_program (.clk, .srst, .boot_size_select_hi,
    .boot_size_select_lo, .osc_tick, .ctrl_wr, .ctrl_wdata, .eeprom_write_active,
    .store_req, .pointer, .store_data, .fetch_addr, .load_req, .load_ptr,
    .self_program_enable, .region_busy_flag, .cpu_halt, .fetch_stall, .load_stall,
    .op_done, .flash_erase, .flash_write, .flash_lock, .page_select_field,
    .buf_word_addr, .buf_word_data, .buf_load, .buf_clear, .load_word_addr,
    .load_byte_hi, .boot_start, .app_end);
  bsp_core_model i_bsp_core_model (.clk, .self_program_enable, .eeprom_write_active,
    .ctrl_wr, .ctrl_wdata, .store_req, .pointer, .store_data);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [11:0] exp_boot(input logic [1:0] f);
    return f == 2'b11 ? 12'hF80 : f == 2'b10 ? 12'hF00 : f == 2'b01 ? 12'hE00 : 12'hC00;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Counts oscillator ticks up to completion; pulses reset once when rst_at is reached.
  task automatic wait_done(input int rst_at);
    int t;
    t = 0;
    for (int n = 0; n < 4000 && op_done !== 1'b1; n++) begin
      srst = (n == rst_at);
      t += int'(osc_tick);
      @(negedge clk);
    end
    check("done", 16'(op_done), 16'h1);
    check("time ok", 16'(t >= bsp_pkg::PROG_TICKS - 1 && t <= bsp_pkg::PROG_TICK_MAX), 16'h1);
    check("enable off", 16'(self_program_enable), 16'h0);
    check("halt off", 16'(cpu_halt), 16'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] p, q;
    repeat (20) @(negedge clk);
    check("clr reset", 16'(buf_clear), 16'h1);
    srst = 1'b0;
    for (int f = 0; f < 4; f++) begin
      @(negedge clk);
      {boot_size_select_hi, boot_size_select_lo} = f[1:0];
      #1;
      check("boot start", 16'(boot_start), 16'(exp_boot(f[1:0])));
      check("app end", 16'(app_end), 16'(exp_boot(f[1:0]) - 12'h001));
    end
    @(negedge clk);
    load_req = 1'b1;
    repeat (8) begin
      r = rnd();
      load_ptr = r[15:0];
      #1;
      check("load word", 16'(load_word_addr), 16'(r[12:1]));
      check("byte sel", 16'(load_byte_hi), 16'(r[0]));
      @(negedge clk);
    end
    r = rnd();
    p = {r[15:13], 7'(r[22:16] % 96), r[5:0]};
    i_bsp_core_model.issue(8'h83, p, r[31:16], 1);
    check("erase", 16'(flash_erase), 16'h1);
    check("page", 16'(page_select_field), 16'(p[12:6]));
    check("busy set", 16'(region_busy_flag), 16'h1);
    check("no halt", 16'(cpu_halt), 16'h0);
    fetch_addr = 12'hBFF;
    load_ptr = 16'h17FE;
    #1;
    check("rww fetch", 16'(fetch_stall), 16'h1);
    check("rww load", 16'(load_stall), 16'h1);
    fetch_addr = 12'hC00;
    load_ptr = 16'h1800;
    #1;
    check("no_read_while_write_region fetch", 16'(fetch_stall), 16'h0);
    check("no_read_while_write_region load", 16'(load_stall), 16'h0);
    wait_done(-1);
    check("busy held", 16'(region_busy_flag), 16'h1);
    i_bsp_core_model.issue(8'h11, 16'h0000, 16'h0000, 1);
    check("clr reen", 16'(buf_clear), 16'h1);
    @(negedge clk);
    check("busy clr", 16'(region_busy_flag), 16'h0);
    repeat (4) begin
      r = rnd();
      q = {r[15:13], p[12:6], r[5:1], 1'b0};
      i_bsp_core_model.issue(8'h01, q, r[31:16], r[17]);
      check("buf load", 16'(buf_load), 16'h1);
      check("buf word", 16'(buf_word_addr), 16'(q[5:1]));
      check("buf data", buf_word_data, r[31:16]);
    end
    i_bsp_core_model.issue(8'h05, {p[15:6], 6'h00}, 16'h0000, 1);
    check("write", 16'(flash_write), 16'h1);
    wait_done(-1);
    check("clr write", 16'(buf_clear), 16'h1);
    i_bsp_core_model.issue(8'h01, {p[15:6], 6'h00}, r[15:0], 1);
    @(negedge clk);
    check("load clr", 16'(region_busy_flag), 16'h0);
    r = rnd();
    i_bsp_core_model.issue(8'h85, {r[15:13], 2'b11, r[20:16], 6'h00}, 16'h0000, 0);
    check("page hi", 16'(page_select_field), {9'h000, 2'b11, r[20:16]});
    check("halt", 16'(cpu_halt), 16'h1);
    check("no busy", 16'(region_busy_flag), 16'h0);
    wait_done(8);
    i_bsp_core_model.issue(8'h89, 16'h0001, 16'h0000, 1);
    check("lock", 16'(flash_lock), 16'h1);
    wait_done(-1);
    eeprom_write_active = 1'b1;
    fork
      begin
        repeat (6) @(negedge clk);
        check("ee block", 16'(self_program_enable), 16'h0);
        eeprom_write_active = 1'b0;
      end
    join_none
    i_bsp_core_model.issue(8'h03, p, 16'h0000, 6);
    check("lapsed", 16'(flash_erase), 16'h0);
    check("lapse idle", 16'(self_program_enable), 16'h0);
    wrap_up();
  end
  initial begin
    #240000;
    n_fail++;
    wrap_up();
  end
endmodule
